// ### rtl/two_wire_iface.sv
`timescale 1ns/1ps
module two_wire_iface
   import two_wire_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // power control
   input wire logic twowire_power_off_bit,
   // master command port
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_nack,
   output logic cmd_ready,
   output logic cmd_done,
   output logic cmd_err,
   output logic ack_rx,
   output logic [7:0] rd_data,
   output logic bus_busy,
   // slave port
   input wire logic [6:0] own_addr,
   input wire logic gc_enable,
   input wire logic slv_ack_en,
   input wire logic [7:0] slv_tx_data,
   output logic slv_rx_valid,
   output logic [7:0] slv_rx_data,
   output logic slv_tx_load,
   output logic slv_addressed,
   output logic slv_gcall,
   // bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   localparam logic [15:0] HALF_M1 = HALF_CYC - 16'h0001;
   localparam logic [15:0] QUARTER_M1 = QUARTER_CYC - 16'h0001;

   typedef struct packed {
      mst_state_t ms;
      logic [15:0] mcnt;
      logic [3:0] mbit;
      logic mread;
      logic mnack_tx;
      logic [7:0] msh;
      logic m_to_stop;
      logic m_pkt;
      logic m_own;
      logic m_sda;
      logic scl_oe;
      logic cmd_ready;
      logic done;
      logic err;
      logic ack_rx;
      logic [7:0] rd_data;
      logic scl_q;
      logic sda_q;
      logic busy;
      slv_state_t ss;
      logic [3:0] scnt;
      logic [7:0] ssh;
      logic s_sda;
      logic s_read;
      logic s_mack;
      logic s_rx_valid;
      logic [7:0] s_rx_data;
      logic s_tx_load;
      logic s_addressed;
      logic s_gcall;
      logic sda_oe;
   } st_t;

   st_t r_r;
   st_t r_nxt;
   logic scl_s;
   logic sda_s;

   bus_line_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({scl_in, sda_in}),
      .q({scl_s, sda_s})
   );

   function automatic logic addr_match(input logic [6:0] a, input logic [6:0] own);
      addr_match = (a == own) && (own[6:3] != RESERVED_PREFIX);
   endfunction : addr_match

   always_comb
   begin
      logic start_det;
      logic stop_det;
      logic scl_rise;
      logic scl_fall;
      logic take;
      logic hit_own;
      logic hit_gc;
      start_det = 1'b0;
      stop_det = 1'b0;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      take = 1'b0;
      hit_own = 1'b0;
      hit_gc = 1'b0;
      r_nxt = r_r;
      r_nxt.done = 1'b0;
      r_nxt.s_rx_valid = 1'b0;
      r_nxt.s_tx_load = 1'b0;
      r_nxt.scl_q = scl_s;
      r_nxt.sda_q = sda_s;
      start_det = scl_s && r_r.scl_q && r_r.sda_q && !sda_s;
      stop_det = scl_s && r_r.scl_q && !r_r.sda_q && sda_s;
      scl_rise = scl_s && !r_r.scl_q;
      scl_fall = !scl_s && r_r.scl_q;
      take = cmd_valid && r_r.cmd_ready;
      if (start_det)
      begin
         r_nxt.busy = 1'b1;
      end
      else if (stop_det)
      begin
         r_nxt.busy = 1'b0;
      end
      // master
      unique case (r_r.ms)
         M_IDLE:
         begin
            r_nxt.cmd_ready = 1'b1;
            if (take)
            begin
               if (cmd_t'(cmd_op) == CMD_START && !r_r.busy)
               begin
                  r_nxt.cmd_ready = 1'b0;
                  r_nxt.ms = M_START;
                  r_nxt.mcnt = '0;
                  r_nxt.m_own = 1'b1;
               end
               else
               begin
                  r_nxt.done = 1'b1;
                  r_nxt.err = 1'b1;
               end
            end
         end
         M_START:
         begin
            r_nxt.m_sda = 1'b1;
            r_nxt.mcnt = r_r.mcnt + 16'h0001;
            if (r_r.mcnt == HALF_M1)
            begin
               r_nxt.scl_oe = 1'b1;
               r_nxt.ms = M_HOLD;
               r_nxt.m_pkt = 1'b0;
               r_nxt.done = 1'b1;
               r_nxt.err = 1'b0;
               r_nxt.cmd_ready = 1'b1;
            end
         end
         M_HOLD:
         begin
            // let go of data one cycle after the clock went low
            r_nxt.m_sda = 1'b0;
            if (take)
            begin
               r_nxt.cmd_ready = 1'b0;
               r_nxt.mcnt = '0;
               r_nxt.mbit = '0;
               r_nxt.err = 1'b0;
               unique case (cmd_t'(cmd_op))
                  CMD_START:
                  begin
                     r_nxt.m_sda = 1'b0;
                     r_nxt.ms = M_RS_LOW;
                  end
                  CMD_WRITE:
                  begin
                     r_nxt.msh = cmd_data;
                     r_nxt.mread = 1'b0;
                     r_nxt.ms = M_BIT_LOW;
                  end
                  CMD_READ:
                  begin
                     r_nxt.mread = 1'b1;
                     r_nxt.mnack_tx = cmd_nack;
                     r_nxt.ms = M_BIT_LOW;
                  end
                  CMD_STOP:
                  begin
                     if (r_r.m_pkt)
                     begin
                        r_nxt.m_sda = 1'b1;
                        r_nxt.ms = M_STOP_LOW;
                     end
                     else
                     begin
                        r_nxt.cmd_ready = 1'b1;
                        r_nxt.done = 1'b1;
                        r_nxt.err = 1'b1;
                     end
                  end
               endcase
            end
         end
         M_RS_LOW, M_STOP_LOW:
         begin
            r_nxt.mcnt = r_r.mcnt + 16'h0001;
            if (r_r.mcnt == QUARTER_M1)
            begin
               r_nxt.scl_oe = 1'b0;
               r_nxt.m_to_stop = (r_r.ms == M_STOP_LOW);
               r_nxt.mcnt = '0;
               r_nxt.ms = M_RISE;
            end
         end
         M_RISE:
         begin
            if (scl_s)
            begin
               r_nxt.mcnt = r_r.mcnt + 16'h0001;
               if (r_r.mcnt == QUARTER_M1)
               begin
                  r_nxt.mcnt = '0;
                  if (r_r.m_to_stop)
                  begin
                     r_nxt.m_sda = 1'b0;
                     r_nxt.ms = M_STOP_END;
                  end
                  else
                  begin
                     r_nxt.ms = M_START;
                  end
               end
            end
         end
         M_STOP_END:
         begin
            r_nxt.mcnt = r_r.mcnt + 16'h0001;
            if (r_r.mcnt == HALF_M1)
            begin
               r_nxt.ms = M_IDLE;
               r_nxt.m_own = 1'b0;
               r_nxt.done = 1'b1;
               r_nxt.cmd_ready = 1'b1;
            end
         end
         M_BIT_LOW:
         begin
            r_nxt.mcnt = r_r.mcnt + 16'h0001;
            if (r_r.mcnt == QUARTER_M1)
            begin
               if (r_r.mbit < ACK_BIT_IDX)
               begin
                  r_nxt.m_sda = r_r.mread ? 1'b0 : !r_r.msh[7];
               end
               else
               begin
                  r_nxt.m_sda = r_r.mread ? !r_r.mnack_tx : 1'b0;
               end
            end
            if (r_r.mcnt == HALF_M1)
            begin
               r_nxt.scl_oe = 1'b0;
               r_nxt.mcnt = '0;
               r_nxt.ms = M_BIT_HIGH;
            end
         end
         M_BIT_HIGH:
         begin
            if (scl_s)
            begin
               r_nxt.mcnt = r_r.mcnt + 16'h0001;
               if (r_r.mcnt == QUARTER_M1)
               begin
                  if (r_r.mbit < ACK_BIT_IDX)
                  begin
                     r_nxt.msh = {r_r.msh[6:0], sda_s};
                  end
                  else
                  begin
                     r_nxt.ack_rx = !sda_s;
                  end
               end
               if (r_r.mcnt == HALF_M1)
               begin
                  r_nxt.scl_oe = 1'b1;
                  r_nxt.mcnt = '0;
                  if (r_r.mbit == ACK_BIT_IDX)
                  begin
                     r_nxt.ms = M_HOLD;
                     r_nxt.m_pkt = 1'b1;
                     r_nxt.rd_data = r_r.msh;
                     r_nxt.done = 1'b1;
                     r_nxt.cmd_ready = 1'b1;
                  end
                  else
                  begin
                     r_nxt.mbit = r_r.mbit + 4'h1;
                     r_nxt.ms = M_BIT_LOW;
                  end
               end
            end
         end
      endcase
      // slave
      if (r_r.m_own || stop_det)
      begin
         r_nxt.ss = S_IDLE;
         r_nxt.s_sda = 1'b0;
         r_nxt.s_addressed = 1'b0;
         r_nxt.s_gcall = 1'b0;
      end
      else if (start_det)
      begin
         r_nxt.ss = S_ADDR;
         r_nxt.scnt = '0;
         r_nxt.s_sda = 1'b0;
         r_nxt.s_addressed = 1'b0;
         r_nxt.s_gcall = 1'b0;
      end
      else
      begin
         unique case (r_r.ss)
            S_IDLE, S_WAIT:
            begin
               r_nxt.s_sda = 1'b0;
            end
            S_ADDR, S_RX:
            begin
               if (scl_rise && r_r.scnt < ACK_BIT_IDX)
               begin
                  r_nxt.ssh = {r_r.ssh[6:0], sda_s};
                  r_nxt.scnt = r_r.scnt + 4'h1;
               end
               else if (scl_rise && r_r.scnt == ACK_BIT_IDX)
               begin
                  r_nxt.scnt = ACK_DONE_IDX;
               end
               else if (scl_fall && r_r.scnt == ACK_BIT_IDX)
               begin
                  if (r_r.ss == S_ADDR)
                  begin
                     hit_own = addr_match(r_r.ssh[7:1], own_addr);
                     hit_gc = (r_r.ssh[7:1] == GEN_CALL_ADDR) && !r_r.ssh[0] && gc_enable;
                     r_nxt.s_read = r_r.ssh[0];
                     if ((hit_own || hit_gc) && slv_ack_en)
                     begin
                        r_nxt.s_sda = 1'b1;
                        r_nxt.s_addressed = 1'b1;
                        r_nxt.s_gcall = hit_gc;
                     end
                  end
                  else
                  begin
                     r_nxt.s_rx_valid = 1'b1;
                     r_nxt.s_rx_data = r_r.ssh;
                     r_nxt.s_sda = slv_ack_en;
                  end
               end
               else if (scl_fall && r_r.scnt == ACK_DONE_IDX)
               begin
                  r_nxt.s_sda = 1'b0;
                  r_nxt.scnt = '0;
                  if (!r_r.s_sda)
                  begin
                     r_nxt.ss = S_WAIT;
                  end
                  else if (r_r.ss == S_ADDR && r_r.s_read)
                  begin
                     r_nxt.ss = S_TX;
                     r_nxt.ssh = slv_tx_data;
                     r_nxt.s_sda = !slv_tx_data[7];
                     r_nxt.s_tx_load = 1'b1;
                  end
                  else
                  begin
                     r_nxt.ss = S_RX;
                  end
               end
            end
            S_TX:
            begin
               if (scl_rise)
               begin
                  r_nxt.scnt = r_r.scnt + 4'h1;
                  if (r_r.scnt == ACK_BIT_IDX)
                  begin
                     r_nxt.s_mack = !sda_s;
                  end
               end
               else if (scl_fall && r_r.scnt < ACK_BIT_IDX && r_r.scnt != 4'h0)
               begin
                  r_nxt.ssh = {r_r.ssh[6:0], 1'b0};
                  r_nxt.s_sda = !r_r.ssh[6];
               end
               else if (scl_fall && r_r.scnt == ACK_BIT_IDX)
               begin
                  r_nxt.s_sda = 1'b0;
               end
               else if (scl_fall && r_r.scnt == ACK_DONE_IDX)
               begin
                  r_nxt.scnt = '0;
                  if (r_r.s_mack)
                  begin
                     r_nxt.ssh = slv_tx_data;
                     r_nxt.s_sda = !slv_tx_data[7];
                     r_nxt.s_tx_load = 1'b1;
                  end
                  else
                  begin
                     r_nxt.ss = S_WAIT;
                  end
               end
            end
         endcase
      end
      r_nxt.sda_oe = r_nxt.m_sda || r_nxt.s_sda;
      if (twowire_power_off_bit)
      begin
         r_nxt = '0;
         r_nxt.scl_q = scl_s;
         r_nxt.sda_q = sda_s;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r_r <= '0;
         // line history starts at the idle level, no false edge
         r_r.scl_q <= 1'b1;
         r_r.sda_q <= 1'b1;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign cmd_ready = r_r.cmd_ready;
   assign cmd_done = r_r.done;
   assign cmd_err = r_r.err;
   assign ack_rx = r_r.ack_rx;
   assign rd_data = r_r.rd_data;
   assign bus_busy = r_r.busy;
   assign slv_rx_valid = r_r.s_rx_valid;
   assign slv_rx_data = r_r.s_rx_data;
   assign slv_tx_load = r_r.s_tx_load;
   assign slv_addressed = r_r.s_addressed;
   assign slv_gcall = r_r.s_gcall;
   assign scl_out = 1'b0;
   assign scl_oe = r_r.scl_oe;
   assign sda_out = 1'b0;
   assign sda_oe = r_r.sda_oe;
endmodule : two_wire_iface

// ### rtl/two_wire_pkg.sv
package two_wire_pkg;

   // system clock and bus timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_HALF_NS = 5000;
   localparam logic [15:0] HALF_CYC = 16'(SCL_HALF_NS / CLK_PERIOD_NS);
   localparam logic [15:0] QUARTER_CYC = 16'(SCL_HALF_NS / (2 * CLK_PERIOD_NS));

   // address fields and bit counter indices
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [3:0] RESERVED_PREFIX = 4'hf;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   localparam logic [3:0] ACK_DONE_IDX = 4'h9;

   typedef enum logic [1:0] {
      CMD_START,
      CMD_WRITE,
      CMD_READ,
      CMD_STOP
   } cmd_t;

   typedef enum logic [3:0] {
      M_IDLE,
      M_START,
      M_HOLD,
      M_RS_LOW,
      M_STOP_LOW,
      M_RISE,
      M_STOP_END,
      M_BIT_LOW,
      M_BIT_HIGH
   } mst_state_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_RX,
      S_TX,
      S_WAIT
   } slv_state_t;

endpackage : two_wire_pkg

// ### rtl/bus_line_sync.sv
`timescale 1ns/1ps
module bus_line_sync #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // lines
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t r_r;
   sync_t r_nxt;

   always_comb
   begin
      r_nxt.s1 = d;
      r_nxt.s2 = r_r.s1;
   end

   // idle bus reads high
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r_r <= '1;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign q = r_r.s2;
endmodule : bus_line_sync

// ### tb/two_wire_iface_sva.sv
`timescale 1ns/1ps
module two_wire_iface_sva
   import two_wire_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // command side
   input wire logic twowire_power_off_bit,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic cmd_ready,
   input wire logic cmd_done,
   input wire logic cmd_err,
   input wire logic bus_busy,
   // slave status
   input wire logic slv_addressed,
   input wire logic slv_gcall,
   // bus pins
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic take;
   logic start_op;
   assign take = cmd_valid && cmd_ready;
   assign start_op = cmd_op == 2'(CMD_START);
   a_drive_low_only: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("bus pin driven high");
   a_power_off_idle: assert property (twowire_power_off_bit |=> !cmd_ready && !scl_oe && !sda_oe)
      else $error("block active while powered off");
   a_start_frame: assert property (take && start_op && !bus_busy && !twowire_power_off_bit
      |-> ##2 (sda_oe && !scl_oe) [*8])
      else $error("start not framed with clock high");
   a_refuse_idle: assert property (take && !start_op && !bus_busy |-> ##[1:2] cmd_done && cmd_err)
      else $error("command outside transaction accepted");
   a_busy_refused: assert property (take && start_op && bus_busy && !scl_oe |-> ##[1:2] cmd_done && cmd_err)
      else $error("start taken on busy bus");
   a_done_pulse: assert property (cmd_done |=> !cmd_done)
      else $error("done longer than one cycle");
   a_start_seen: assert property (scl_in && $past(scl_in) && $fell(sda_in) && !twowire_power_off_bit
      |-> ##[1:8] bus_busy)
      else $error("start not detected");
   a_stop_seen: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !bus_busy)
      else $error("stop not detected");
   a_slave_ack_drive: assert property ($rose(slv_addressed) |-> sda_oe)
      else $error("address match without ack");
   a_slave_stable: assert property (slv_addressed && $changed(sda_oe) |-> !scl_in)
      else $error("slave data changed with clock high");
   a_gcall_ack: assert property ($rose(slv_gcall) |-> slv_addressed && sda_oe)
      else $error("general call flagged without ack");
   c_refused: cover property (cmd_done && cmd_err);
   c_master_done: cover property (cmd_done && !cmd_err);
   c_slave_hit: cover property ($rose(slv_addressed));
   c_gcall: cover property ($rose(slv_gcall));
endmodule : two_wire_iface_sva

bind two_wire_iface two_wire_iface_sva i_two_wire_iface_sva (.clk(clk), .rstn(rstn),
   .twowire_power_off_bit(twowire_power_off_bit), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_err(cmd_err), .bus_busy(bus_busy),
   .slv_addressed(slv_addressed), .slv_gcall(slv_gcall), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ### tb/bus_peer.sv
`timescale 1ns/1ps
module bus_peer #(
   parameter logic [6:0] PEER_ADDR = 7'h5a
) (
   // wire levels
   input wire logic scl_w,
   input wire logic sda_w,
   // pulls, high drives the line low
   output logic scl_lo,
   output logic sda_lo
);
   logic s_sda = 1'b0, st_scl = 1'b0, m_sda = 1'b0, m_scl = 1'b0, act = 1'b0, rd = 1'b0, mack = 1'b0;
   logic [7:0] sh = 8'h00, tx = 8'h00;
   logic [7:0] rx_q[$];
   int phase = 0, cnt = 0, stretch = 0;
   assign scl_lo = st_scl | m_scl;
   assign sda_lo = s_sda | m_sda;
   // slave side framing
   always @(negedge sda_w)
      if (scl_w === 1'b1)
      begin
         phase = 1;
         cnt = -1;
      end
   always @(posedge sda_w)
      if (scl_w === 1'b1)
         phase = 0;
   always @(posedge scl_w)
      if (phase != 0 && cnt >= 0)
      begin
         if (cnt < 8)
            sh = {sh[6:0], sda_w};
         else
            mack = !sda_w;
      end
   // pull only after the fall, so data never moves with clock high
   always @(negedge scl_w)
      if (phase != 0)
      begin
         if (stretch > 0)
         begin
            st_scl = 1'b1;
            st_scl <= #(stretch) 1'b0;
         end
         if (cnt == 7)
         begin
            if (phase == 1)
            begin
               act = sh[7:1] == PEER_ADDR;
               rd = sh[0];
            end
            if (phase == 2 || (phase == 1 && act))
               rx_q.push_back(sh);
            if (phase == 3)
               tx = tx + 8'h01;
            s_sda <= #30 (phase == 1 && act) || phase == 2;
         end
         else if (cnt == 8)
         begin
            if (phase == 1)
               phase = !act ? 4 : rd ? 3 : 2;
            else if (phase == 3 && !mack)
               phase = 4;
            s_sda <= #30 phase == 3 && !tx[7];
         end
         else if (cnt >= 0)
            s_sda <= #30 phase == 3 && !tx[6-cnt];
         cnt = cnt == 8 ? 0 : cnt + 1;
      end
   // master side, 200 ns bit period
   task automatic m_start();
      if (m_scl)
      begin
         m_sda = 1'b0;
         #50;
         m_scl = 1'b0;
         wait (scl_w === 1'b1);
         #100;
      end
      m_sda = 1'b1;
      #100;
      m_scl = 1'b1;
      #50;
   endtask : m_start
   task automatic m_bit(input logic v, output logic s);
      m_sda = ~v;
      #50;
      m_scl = 1'b0;
      wait (scl_w === 1'b1);
      #50;
      s = sda_w;
      #50;
      m_scl = 1'b1;
      #50;
   endtask : m_bit
   task automatic m_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         m_bit(b[i], s);
      m_bit(1'b1, s);
      ack = ~s;
   endtask : m_byte
   task automatic m_read(output logic [7:0] b, input logic nack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         m_bit(1'b1, s);
         b[i] = s;
      end
      m_bit(nack, s);
   endtask : m_read
   task automatic m_stop();
      m_sda = 1'b1;
      #50;
      m_scl = 1'b0;
      wait (scl_w === 1'b1);
      #100;
      m_sda = 1'b0;
      #100;
   endtask : m_stop
endmodule : bus_peer

// ### tb/tb_two_wire_bus_protocol.sv
`timescale 1ns/1ps
module tb_two_wire_bus_protocol
   import two_wire_pkg::*;
;
   localparam logic [6:0] PEER_ADDR = 7'h5a;
   localparam int LIMIT = 60000;
   logic clk = 1'b0, rstn, twowire_power_off_bit, cmd_valid, cmd_nack, gc_enable, slv_ack_en;
   logic [1:0] cmd_op;
   logic [7:0] cmd_data, slv_tx_data, rd_data, slv_rx_data, d, tx_exp;
   logic [6:0] own_addr, o;
   logic cmd_ready, cmd_done, cmd_err, ack_rx, bus_busy, slv_rx_valid, slv_tx_load, slv_addressed, slv_gcall;
   logic scl_out, scl_oe, sda_out, sda_oe, p_scl_lo, p_sda_lo, scl_w, sda_w;
   int miscompares = 0, n_checks = 0, cyc = 0, n_rxv = 0, n_txl = 0;
   // wired-and with pull-ups
   assign scl_w = (scl_oe ? scl_out : 1'b1) & ~p_scl_lo;
   assign sda_w = (sda_oe ? sda_out : 1'b1) & ~p_sda_lo;
   always #12.5 clk = ~clk;
   // slave strobes counted where they are settled
   always @(negedge clk)
   begin
      n_rxv += int'(slv_rx_valid);
      n_txl += int'(slv_tx_load);
   end
   two_wire_iface i_two_wire_iface (.clk(clk), .rstn(rstn), .twowire_power_off_bit(twowire_power_off_bit),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .ack_rx(ack_rx), .rd_data(rd_data), .bus_busy(bus_busy),
      .own_addr(own_addr), .gc_enable(gc_enable), .slv_ack_en(slv_ack_en), .slv_tx_data(slv_tx_data),
      .slv_rx_valid(slv_rx_valid), .slv_rx_data(slv_rx_data), .slv_tx_load(slv_tx_load),
      .slv_addressed(slv_addressed), .slv_gcall(slv_gcall), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
   bus_peer #(.PEER_ADDR(PEER_ADDR)) i_bus_peer (.scl_w(scl_w), .sda_w(sda_w), .scl_lo(p_scl_lo),
      .sda_lo(p_sda_lo));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic cmd(input cmd_t op, input logic [7:0] dat, input logic nk, input logic err);
      int n;
      n = 0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_data = dat;
      cmd_nack = nk;
      while (cmd_ready !== 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_done !== 1'b1 && n < 40000)
      begin
         @(negedge clk);
         n++;
      end
      chk(8'({cmd_done, cmd_err}), 8'({1'b1, err}));
   endtask : cmd
   // model: peer acks only its own address
   task automatic mtxn(input logic [6:0] a, input logic [7:0] dat);
      cmd(CMD_START, 8'h00, 1'b0, 1'b0);
      cmd(CMD_WRITE, {a, 1'b0}, 1'b0, 1'b0);
      chk(8'(ack_rx), 8'(a == PEER_ADDR));
      if (a == PEER_ADDR)
      begin
         cmd(CMD_WRITE, dat, 1'b0, 1'b0);
         chk(i_bus_peer.rx_q[$], dat);
      end
      cmd(CMD_STOP, 8'h00, 1'b0, 1'b0);
   endtask : mtxn
   // model of the slave answer to an address
   task automatic stxn(input logic [6:0] a, input logic rw);
      logic exp, ak;
      logic [7:0] b;
      int rx0, tx0;
      exp = slv_ack_en && ((a == own_addr && own_addr[6:3] != 4'hf) || (a == 7'h00 && gc_enable && !rw));
      rx0 = n_rxv;
      tx0 = n_txl;
      @(negedge clk);
      d = 8'($urandom);
      slv_tx_data = d;
      i_bus_peer.m_start();
      i_bus_peer.m_byte({a, rw}, ak);
      chk(8'(ak), 8'(exp));
      chk(8'(slv_addressed), 8'(exp));
      if (exp && !rw)
      begin
         i_bus_peer.m_byte(d, ak);
         chk(8'(ak), 8'h01);
         chk(slv_rx_data, d);
         chk(8'(slv_gcall), 8'(a == 7'h00));
      end
      if (exp && rw)
      begin
         i_bus_peer.m_read(b, 1'b1);
         chk(b, d);
      end
      i_bus_peer.m_stop();
      chk(8'(n_rxv - rx0), 8'(exp && !rw));
      chk(8'(n_txl - tx0), 8'(exp && rw));
   endtask : stxn
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         miscompares++;
         end_sim();
      end
   end
   initial
   begin
      void'($urandom(56));
      {rstn, twowire_power_off_bit, cmd_valid, cmd_nack, gc_enable, slv_ack_en} = 6'h00;
      {cmd_op, cmd_data, slv_tx_data, own_addr} = 25'h000_0000;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      chk(8'({scl_oe, sda_oe, bus_busy, cmd_ready}), 8'h00);
      for (int op = 1; op < 4; op++)
         cmd(cmd_t'(op), 8'h00, 1'b0, 1'b1);
      d = 8'($urandom);
      tx_exp = 8'($urandom);
      i_bus_peer.tx = tx_exp;
      cmd(CMD_START, 8'h00, 1'b0, 1'b0);
      chk(8'(bus_busy), 8'h01);
      cmd(CMD_STOP, 8'h00, 1'b0, 1'b1);
      cmd(CMD_WRITE, {PEER_ADDR, 1'b0}, 1'b0, 1'b0);
      chk(8'(ack_rx), 8'h01);
      cmd(CMD_WRITE, d, 1'b0, 1'b0);
      chk(rd_data, d);
      chk(i_bus_peer.rx_q[$], d);
      cmd(CMD_START, 8'h00, 1'b0, 1'b0);
      chk(8'(bus_busy), 8'h01);
      cmd(CMD_WRITE, {PEER_ADDR, 1'b1}, 1'b0, 1'b0);
      chk(8'(ack_rx), 8'h01);
      for (int i = 0; i < 2; i++)
      begin
         cmd(CMD_READ, 8'h00, 1'(i), 1'b0);
         chk(rd_data, tx_exp);
         tx_exp++;
      end
      cmd(CMD_STOP, 8'h00, 1'b0, 1'b0);
      chk(8'(bus_busy), 8'h00);
      mtxn(PEER_ADDR ^ 7'h01, d);
      i_bus_peer.stretch = 8000;
      mtxn(PEER_ADDR, 8'($urandom));
      i_bus_peer.stretch = 0;
      o = {2'b01, 5'($urandom)};
      i_bus_peer.m_start();
      cmd(CMD_START, 8'h00, 1'b0, 1'b1);
      i_bus_peer.m_byte(8'h22, d[0]);
      i_bus_peer.m_stop();
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         gc_enable = i inside {2, 3};
         slv_ack_en = i != 5;
         own_addr = i == 6 ? 7'h7c : o;
         stxn(i inside {2, 3, 4} ? 7'h00 : i == 7 ? o ^ 7'h01 : own_addr, i inside {1, 3});
      end
      @(negedge clk);
      twowire_power_off_bit = 1'b1;
      cmd_valid = 1'b1;
      cmd_op = CMD_START;
      repeat (20) @(negedge clk);
      chk(8'({cmd_ready, scl_oe, sda_oe, cmd_done}), 8'h00);
      cmd_valid = 1'b0;
      twowire_power_off_bit = 1'b0;
      end_sim();
   end
endmodule : tb_two_wire_bus_protocol
